//--- src/cspc_top.sv
// Functional notes
// (RQ1) reset pin held high selects pin-only control
// (RQ2) pin-only: serial pins are static control inputs
// (RQ3) straps configure device after power-up without reset
// (RQ4) pin-only: select pin picks gain and reference
// (RQ5) pin-only: clock/data pins pick pattern or powerdown
// (RQ6) power-down pin forces global power down
// (RQ7) interface strap sets wires and bit-clock rate
// (RQ8) serialization strap sets factor and capture edge
// (RQ9) format strap sets bit order and coding
// (RQ10) serial modes: serial pins write registers
// (RQ11) host resets registers before serial programming
// (RQ12) host holds reset pin low afterwards
// (RQ13) host sets override bit for serial-only
// (RQ14) combined strap and register configuration supported
// (RQ15) override low: straps rule; high: registers rule
// (RQ16) register power-down bit acts only pin low
// (RQ17) power-down pin high forces power down
// (RQ18) gain register only with override, else 0 dB
// (RQ19) serial modes: reference from register bit
// (RQ20) serial modes: patterns from register field only
// (RQ21) serial modes: power down from register only; code ORs the power-down pin with the register bit
// (RQ22) clock/data decode: normal, sync, powerdown, deskew
// (RQ23) interface strap decode, lower-middle level unused
// (RQ24) soft reset restores defaults, clears itself
// (RQ25) format strap decode four combinations
// (RQ26) straps decoded to two-bit codes, then muxed
`timescale 1ns/1ps
`default_nettype none
module cspc_top
(
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic HW_RESET_I,
  input wire logic PDN_PIN_I,
  input wire logic [1:0] INTERFACE_STRAP_I,
  input wire logic [1:0] SERIALIZATION_STRAP_I,
  input wire logic [1:0] RESERVED_STRAP_I,
  input wire logic [1:0] FORMAT_STRAP_I,
  input wire logic [1:0] SERIAL_SELECT_PIN_I,
  input wire logic SERIAL_CLOCK_PIN_I,
  input wire logic SERIAL_DATA_PIN_I,
  output logic SERIAL_MODE_O,
  output logic TWO_WIRE_O,
  output logic SDR_CLOCK_O,
  output logic SER_16X_O,
  output logic CAPTURE_RISING_O,
  output logic LSB_FIRST_O,
  output logic OFFSET_BINARY_O,
  output logic GLOBAL_PDN_O,
  output logic COARSE_GAIN_O,
  output logic INTERNAL_REF_O,
  output logic [1:0] PATTERN_O,
  output logic OVERRIDE_O
);
  // ==========================================================================
  // reset release
  logic [1:0] rst_sync_r;
  logic rst_n;

  // two-stage release keeps de-assertion clean against the clock
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // ==========================================================================
  // mode selection
  cspc_pkg::cspc_mode_t mode_r;
  logic hw_reset_r;
  logic pin_only;

  // reset pin high means pin-only, otherwise the serial port is live
  always_ff @(posedge CLK_SYS_I or negedge rst_n)
  begin
    if (!rst_n)
      mode_r <= cspc_pkg::CSPC_PIN_ONLY;
    else if (HW_RESET_I)
      mode_r <= cspc_pkg::CSPC_PIN_ONLY; // [RQ1]
    else
      mode_r <= cspc_pkg::CSPC_SERIAL; // [RQ10] [RQ14]
  end
  assign pin_only = (mode_r == cspc_pkg::CSPC_PIN_ONLY);

  // rising reset pin edge marks a register reset pulse in serial use
  always_ff @(posedge CLK_SYS_I or negedge rst_n)
  begin
    if (!rst_n)
      hw_reset_r <= 1'b0;
    else
      hw_reset_r <= HW_RESET_I;
  end

  // ==========================================================================
  // strap decoders
  logic [1:0] iface_code;
  logic [1:0] ser_code;
  logic [1:0] fmt_code;
  logic [1:0] sel_code;

  // each four-level pin except the reserved strap becomes a two-bit code before the muxes [RQ26]
  cspc_strap_dec u_iface
  (
    .clk_i(CLK_SYS_I),
    .rst_n_i(rst_n),
    .level_i(INTERFACE_STRAP_I),
    .code_o(iface_code)
  );
  cspc_strap_dec u_ser
  (
    .clk_i(CLK_SYS_I),
    .rst_n_i(rst_n),
    .level_i(SERIALIZATION_STRAP_I),
    .code_o(ser_code)
  );
  cspc_strap_dec u_fmt
  (
    .clk_i(CLK_SYS_I),
    .rst_n_i(rst_n),
    .level_i(FORMAT_STRAP_I),
    .code_o(fmt_code)
  );
  cspc_strap_dec u_sel
  (
    .clk_i(CLK_SYS_I),
    .rst_n_i(rst_n),
    .level_i(SERIAL_SELECT_PIN_I),
    .code_o(sel_code)
  );

  // ==========================================================================
  // serial port
  logic word_vld;
  logic [15:0] word;
  logic sel_n;

  // select low (ground code) enables shifting; top code is idle high
  assign sel_n = (SERIAL_SELECT_PIN_I != cspc_pkg::LVL_GND);

  cspc_serial_rx u_rx
  (
    .clk_i(CLK_SYS_I),
    .rst_n_i(rst_n),
    .enable_i(!pin_only), // [RQ2]
    .sel_n_i(sel_n),
    .sclk_i(SERIAL_CLOCK_PIN_I),
    .serial_data_pin_i(SERIAL_DATA_PIN_I),
    .word_vld_o(word_vld),
    .word_o(word)
  );

  // ==========================================================================
  // register bank
  logic [10:0] ctrl_r;
  logic [10:0] mode_reg_r;
  logic soft_rst_r;
  logic [4:0] waddr;
  logic [10:0] wdata;
  logic reg_clear;

  assign waddr = word[15:11];
  assign wdata = word[10:0];
  // pin pulse or self-clearing soft reset returns defaults
  assign reg_clear = soft_rst_r || (HW_RESET_I && !hw_reset_r); // [RQ24]

  // soft reset bit is one cycle wide: it clears itself next edge
  always_ff @(posedge CLK_SYS_I or negedge rst_n)
  begin
    if (!rst_n)
      soft_rst_r <= 1'b0;
    else
      soft_rst_r <= word_vld && (waddr == cspc_pkg::ADDR_RESET) &&
                    wdata[cspc_pkg::SOFT_RST_BIT] && !soft_rst_r; // [RQ24]
  end

  // register writes from the serial port
  always_ff @(posedge CLK_SYS_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= cspc_pkg::CTRL_RST;
      mode_reg_r <= cspc_pkg::MODE_RST;
    end
    else if (reg_clear)
    begin
      ctrl_r <= cspc_pkg::CTRL_RST;
      mode_reg_r <= cspc_pkg::MODE_RST;
    end
    else if (word_vld)
    begin
      if (waddr == cspc_pkg::ADDR_CTRL)
        ctrl_r <= wdata; // [RQ10]
      if (waddr == cspc_pkg::ADDR_MODE)
        mode_reg_r <= wdata;
    end
  end

  // ==========================================================================
  // priority multiplexers
  logic ovr;
  logic [1:0] if_sel;
  logic [1:0] sr_sel;
  logic [1:0] fm_sel;
  logic [1:0] pin_pat;
  logic two_wire_nxt;
  logic sdr_nxt;

  assign ovr = !pin_only && ctrl_r[cspc_pkg::OVERRIDE_BIT];

  // straps rule until override is set, then register fields [RQ15]
  assign if_sel = ovr ? mode_reg_r[cspc_pkg::IFACE_LSB +: 2] : iface_code;
  assign sr_sel = ovr ? mode_reg_r[cspc_pkg::SER_LSB +: 2] : ser_code;
  assign fm_sel = ovr ? mode_reg_r[cspc_pkg::FMT_LSB +: 2] : fmt_code;

  // lower-middle level is unused; treated as the ground setting [RQ23]
  always_comb
  begin
    two_wire_nxt = 1'b0;
    sdr_nxt = 1'b0;
    unique case (if_sel)
      cspc_pkg::LVL_GND,
      cspc_pkg::LVL_LO_MID:
      begin
        two_wire_nxt = 1'b0;
        sdr_nxt = 1'b0;
      end
      cspc_pkg::LVL_HI_MID:
      begin
        two_wire_nxt = 1'b1;
        sdr_nxt = 1'b1;
      end
      cspc_pkg::LVL_TOP:
      begin
        two_wire_nxt = 1'b1;
        sdr_nxt = 1'b0;
      end
    endcase
  end

  // pin-only decode of the clock/data pair [RQ22]
  assign pin_pat = !SERIAL_CLOCK_PIN_I && SERIAL_DATA_PIN_I ?
                   cspc_pkg::PAT_SYNC :
                   (SERIAL_CLOCK_PIN_I && SERIAL_DATA_PIN_I ?
                    cspc_pkg::PAT_DESKEW : cspc_pkg::PAT_NORMAL);

  // ==========================================================================
  // registered outputs; reset values give the ground-strap setting until
  // the second edge picks up the straps, with no pin reset needed [RQ3]
  always_ff @(posedge CLK_SYS_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      TWO_WIRE_O <= 1'b0;
      SDR_CLOCK_O <= 1'b0;
      SER_16X_O <= 1'b0;
      CAPTURE_RISING_O <= 1'b0;
      LSB_FIRST_O <= 1'b0;
      OFFSET_BINARY_O <= 1'b0;
    end
    else
    begin
      TWO_WIRE_O <= two_wire_nxt; // [RQ7]
      SDR_CLOCK_O <= sdr_nxt; // [RQ7]
      SER_16X_O <= sr_sel[0] ^ sr_sel[1]; // [RQ8]
      CAPTURE_RISING_O <= sr_sel[1]; // [RQ8]
      LSB_FIRST_O <= fm_sel[1]; // [RQ9] [RQ25]
      OFFSET_BINARY_O <= fm_sel[0] ^ fm_sel[1]; // [RQ9] [RQ25]
    end
  end

  // power, gain, reference and pattern selection
  always_ff @(posedge CLK_SYS_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      GLOBAL_PDN_O <= 1'b0;
      COARSE_GAIN_O <= 1'b0;
      INTERNAL_REF_O <= 1'b0;
      PATTERN_O <= cspc_pkg::PAT_NORMAL;
      SERIAL_MODE_O <= 1'b0;
      OVERRIDE_O <= 1'b0;
    end
    else if (pin_only)
    begin
      // power-down pin overrides all; pair high/low also powers down
      GLOBAL_PDN_O <= PDN_PIN_I ||
                      (SERIAL_CLOCK_PIN_I && !SERIAL_DATA_PIN_I); // [RQ5] [RQ6]
      COARSE_GAIN_O <= sel_code[0] ^ sel_code[1]; // [RQ4]
      INTERNAL_REF_O <= sel_code[1]; // [RQ4]
      PATTERN_O <= pin_pat; // [RQ5] [RQ2]
      SERIAL_MODE_O <= 1'b0;
      OVERRIDE_O <= 1'b0;
    end
    else
    begin
      // register bit only counts while the pin is low [RQ16] [RQ17] [RQ21]
      GLOBAL_PDN_O <= PDN_PIN_I || ctrl_r[cspc_pkg::PDN_GLOBAL_BIT];
      COARSE_GAIN_O <= ovr && ctrl_r[cspc_pkg::COARSE_GAIN_BIT]; // [RQ18]
      INTERNAL_REF_O <= ctrl_r[cspc_pkg::REF_INT_BIT]; // [RQ19]
      PATTERN_O <= ctrl_r[cspc_pkg::PATTERN_LSB +: 2]; // [RQ20]
      SERIAL_MODE_O <= 1'b1;
      OVERRIDE_O <= ovr;
    end
  end
endmodule : cspc_top
`default_nettype wire

//--- src/cspc_pkg.sv
package cspc_pkg;
  // ==========================================================================
  // strap level codes (four-level pins decoded to two bits)
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_LO_MID = 2'h1;
  localparam logic [1:0] LVL_HI_MID = 2'h2;
  localparam logic [1:0] LVL_TOP = 2'h3;

  // ==========================================================================
  // test pattern codes
  localparam logic [1:0] PAT_NORMAL = 2'h0;
  localparam logic [1:0] PAT_SYNC = 2'h1;
  localparam logic [1:0] PAT_DESKEW = 2'h2;

  // ==========================================================================
  // serial word layout: 5 address bits then 11 data bits
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 5;
  localparam int DATA_BITS = 11;

  // register addresses and field positions
  localparam logic [4:0] ADDR_RESET = 5'h00;
  localparam logic [4:0] ADDR_CTRL = 5'h0D;
  localparam logic [4:0] ADDR_MODE = 5'h0E;
  localparam int SOFT_RST_BIT = 1;
  localparam int OVERRIDE_BIT = 10;
  localparam int PDN_GLOBAL_BIT = 0;
  localparam int COARSE_GAIN_BIT = 1;
  localparam int REF_INT_BIT = 2;
  localparam int PATTERN_LSB = 3;
  localparam int IFACE_LSB = 5;
  localparam int SER_LSB = 7;
  localparam int FMT_LSB = 9;

  // register reset values
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam logic [10:0] MODE_RST = 11'h000;

  typedef enum logic [1:0] {CSPC_PIN_ONLY, CSPC_SERIAL} cspc_mode_t;
endpackage : cspc_pkg

//--- src/cspc_strap_dec.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// four-level strap decoder: registers the level code at every edge
module cspc_strap_dec
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] level_i,
  output logic [1:0] code_o
);
  // straps are static, so one register stage is enough
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      code_o <= cspc_pkg::LVL_GND;
    else
      code_o <= level_i;
  end
endmodule : cspc_strap_dec
`default_nettype wire

//--- src/cspc_serial_rx.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// serial word receiver: samples data on falling serial clock, select low
module cspc_serial_rx
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic sel_n_i,
  input wire logic sclk_i,
  input wire logic serial_data_pin_i,
  output logic word_vld_o,
  output logic [15:0] word_o
);
  logic sclk_r;
  logic [3:0] cnt_r;
  logic [15:0] shift_r;
  logic fall;

  assign fall = sclk_r & ~sclk_i & ~sel_n_i & enable_i;

  // edge detector on the sampled serial clock
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sclk_r <= 1'b0;
    else
      sclk_r <= sclk_i;
  end

  // bit counter restarts whenever select goes high, so an unfinished word drops; past sixteen bits it wraps into a new word
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= 4'h0;
      shift_r <= 16'h0000;
    end
    else if (sel_n_i || !enable_i)
      cnt_r <= 4'h0;
    else if (fall)
    begin
      cnt_r <= cnt_r + 4'h1;
      shift_r <= {shift_r[14:0], serial_data_pin_i};
    end
  end

  // word strobe at every sixteenth falling edge
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      word_vld_o <= 1'b0;
      word_o <= 16'h0000;
    end
    else
    begin
      word_vld_o <= fall && (cnt_r == 4'hF);
      if (fall && (cnt_r == 4'hF))
        word_o <= {shift_r[14:0], serial_data_pin_i};
    end
  end
endmodule : cspc_serial_rx
`default_nettype wire

//--- dv/cspc_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checks of the strap and register priority logic
module cspc_checker
(
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic HW_RESET_I,
  input wire logic PDN_PIN_I,
  input wire logic [1:0] INTERFACE_STRAP_I,
  input wire logic [1:0] SERIALIZATION_STRAP_I,
  input wire logic [1:0] FORMAT_STRAP_I,
  input wire logic [1:0] SERIAL_SELECT_PIN_I,
  input wire logic SERIAL_CLOCK_PIN_I,
  input wire logic SERIAL_DATA_PIN_I,
  input wire logic SERIAL_MODE_O,
  input wire logic TWO_WIRE_O,
  input wire logic SDR_CLOCK_O,
  input wire logic SER_16X_O,
  input wire logic CAPTURE_RISING_O,
  input wire logic LSB_FIRST_O,
  input wire logic OFFSET_BINARY_O,
  input wire logic GLOBAL_PDN_O,
  input wire logic COARSE_GAIN_O,
  input wire logic INTERNAL_REF_O,
  input wire logic [1:0] PATTERN_O,
  input wire logic OVERRIDE_O
);
  int rdy_r;
  logic [11:0] pv;
  logic [1:0] pe;
  // pin snapshot and the pattern the two serial pins ask for
  assign pv = {HW_RESET_I, PDN_PIN_I, INTERFACE_STRAP_I,
    SERIALIZATION_STRAP_I, FORMAT_STRAP_I, SERIAL_SELECT_PIN_I,
    SERIAL_CLOCK_PIN_I, SERIAL_DATA_PIN_I};
  assign pe = !SERIAL_DATA_PIN_I ? cspc_pkg::PAT_NORMAL :
    SERIAL_CLOCK_PIN_I ? cspc_pkg::PAT_DESKEW : cspc_pkg::PAT_SYNC;
  // outputs are held low just after reset, so wait before judging
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rdy_r <= 0;
    else if (rdy_r < 8)
      rdy_r <= rdy_r + 1;
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_calm; (rdy_r > 5 && $stable(pv)) [*3]; endsequence
  sequence s_pin; s_calm ##0 HW_RESET_I; endsequence
  sequence s_strap; s_calm ##0 (HW_RESET_I || !OVERRIDE_O); endsequence
  property p_mode; s_calm |-> SERIAL_MODE_O == !HW_RESET_I; endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_pdn; (rdy_r > 5 && PDN_PIN_I) [*3] |-> GLOBAL_PDN_O;
  endproperty
  a_pdn: assert property (p_pdn) else $error("pdn pin lost");
  property p_pat; s_pin |-> PATTERN_O == pe; endproperty
  a_pat: assert property (p_pat) else $error("pin pattern");
  property p_ppd;
    s_pin ##0 (SERIAL_CLOCK_PIN_I && !SERIAL_DATA_PIN_I) |-> GLOBAL_PDN_O;
  endproperty
  a_ppd: assert property (p_ppd) else $error("pin pdn");
  property p_sel;
    s_pin |-> COARSE_GAIN_O == ^SERIAL_SELECT_PIN_I &&
      INTERNAL_REF_O == SERIAL_SELECT_PIN_I[1];
  endproperty
  a_sel: assert property (p_sel) else $error("select pin");
  property p_ifc;
    s_strap |-> TWO_WIRE_O == INTERFACE_STRAP_I[1] &&
      SDR_CLOCK_O == (INTERFACE_STRAP_I == cspc_pkg::LVL_HI_MID);
  endproperty
  a_ifc: assert property (p_ifc) else $error("iface");
  property p_ser;
    s_strap |-> SER_16X_O == ^SERIALIZATION_STRAP_I &&
      CAPTURE_RISING_O == SERIALIZATION_STRAP_I[1];
  endproperty
  a_ser: assert property (p_ser) else $error("serialize");
  property p_fmt;
    s_strap |-> LSB_FIRST_O == FORMAT_STRAP_I[1] &&
      OFFSET_BINARY_O == ^FORMAT_STRAP_I;
  endproperty
  a_fmt: assert property (p_fmt) else $error("format");
  property p_gain; s_calm ##0 !HW_RESET_I && !OVERRIDE_O |-> !COARSE_GAIN_O;
  endproperty
  a_gain: assert property (p_gain) else $error("gain");
endmodule : cspc_checker
bind cspc_top cspc_checker cspc_checker_i (.*);
`default_nettype wire

//--- dv/cspc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// host and board straps; reserved strap is grounded
module cspc_host_model
(
  input wire logic clk_i,
  output logic hw_reset_o,
  output logic pdn_o,
  output logic [1:0] iface_o,
  output logic [1:0] ser_o,
  output logic [1:0] rsv_o,
  output logic [1:0] fmt_o,
  output logic [1:0] sel_o,
  output logic sclk_o,
  output logic serial_data_pin_o
);
  // start in pin-only control, reset pin high
  initial
  begin
    {hw_reset_o, pdn_o, iface_o, ser_o, fmt_o, sel_o, sclk_o, serial_data_pin_o} =
      12'h80C;
    rsv_o = 2'h0;
  end
  // all pins move together, just after an edge
  task drive(input logic [11:0] v);
    @(posedge clk_i);
    #1;
    {hw_reset_o, pdn_o, iface_o, ser_o, fmt_o, sel_o, sclk_o, serial_data_pin_o} = v;
  endtask : drive
  // one word msb first, each clock level held two cycles
  task send(input logic [15:0] w);
    @(posedge clk_i);
    #1;
    sel_o = 2'h0;
    for (int i = 15; i >= 0; i--)
    begin
      serial_data_pin_o = w[i];
      sclk_o = 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      sclk_o = 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
    end
    sel_o = 2'h3;
    serial_data_pin_o = ~serial_data_pin_o; // released data no longer holds its value
  endtask : send
endmodule : cspc_host_model
`default_nettype wire

//--- dv/config_source_priority_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module config_source_priority_control_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire [11:0] p;
  wire [1:0] rsv;
  wire [12:0] act;
  logic [11:0] st = 12'h80C;
  logic [10:0] ctrl = 11'h000;
  logic [10:0] mode = 11'h000;
  logic [15:0] lf = 16'h87D9;
  logic [10:0] d;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  cspc_host_model cspc_host_model_i (.clk_i(clk), .hw_reset_o(p[11]),
    .pdn_o(p[10]), .iface_o(p[9:8]), .ser_o(p[7:6]), .rsv_o(rsv),
    .fmt_o(p[5:4]), .sel_o(p[3:2]), .sclk_o(p[1]), .serial_data_pin_o(p[0]));
  cspc_top cspc_top_i (.CLK_SYS_I(clk), .RST_N_I(rst_n),
    .HW_RESET_I(p[11]), .PDN_PIN_I(p[10]), .INTERFACE_STRAP_I(p[9:8]),
    .SERIALIZATION_STRAP_I(p[7:6]), .RESERVED_STRAP_I(rsv),
    .FORMAT_STRAP_I(p[5:4]), .SERIAL_SELECT_PIN_I(p[3:2]),
    .SERIAL_CLOCK_PIN_I(p[1]), .SERIAL_DATA_PIN_I(p[0]),
    .SERIAL_MODE_O(act[12]), .TWO_WIRE_O(act[11]), .SDR_CLOCK_O(act[10]),
    .SER_16X_O(act[9]), .CAPTURE_RISING_O(act[8]), .LSB_FIRST_O(act[7]),
    .OFFSET_BINARY_O(act[6]), .GLOBAL_PDN_O(act[5]),
    .COARSE_GAIN_O(act[4]), .INTERNAL_REF_O(act[3]), .PATTERN_O(act[2:1]),
    .OVERRIDE_O(act[0]));
  // ==========
  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  // next state of the stimulus shift register; taps give the full period
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // expected outputs from pins and registers
  function automatic logic [12:0] expect_out();
    logic srl, ov, pd, gn, rf;
    logic [1:0] ci, cs, cf, pt;
    srl = !st[11];
    ov = srl & ctrl[10];
    ci = ov ? mode[6:5] : st[9:8];
    cs = ov ? mode[8:7] : st[7:6];
    cf = ov ? mode[10:9] : st[5:4];
    gn = srl ? ov & ctrl[1] : ^st[3:2];
    rf = srl ? ctrl[2] : st[3];
    pt = srl ? ctrl[4:3] : !st[0] ? 2'h0 : st[1] ? 2'h2 : 2'h1;
    pd = st[10] | (srl ? ctrl[0] : st[1] & !st[0]);
    return {srl, ci[1], ci == 2'h2, ^cs, cs[1], cf[1], ^cf, pd, gn, rf, pt,
      ov};
  endfunction : expect_out
  // compare after the outputs have settled
  task chk();
    repeat (5) @(posedge clk);
    #2;
    checked++;
    if (act !== expect_out())
    begin
      mismatches++;
      $display("ERROR t=%0t exp=%h got=%h", $time, expect_out(), act);
    end
  endtask : chk
  // a rising reset pin clears the registers
  task apply(input logic [11:0] v);
    if (v[11] && !st[11])
      {ctrl, mode} = 22'h000000;
    cspc_host_model_i.drive(v);
    st = v;
  endtask : apply
  task wr(input logic [4:0] a, input logic [10:0] v);
    cspc_host_model_i.send({a, v});
    if (a == 5'h00 && v[1])
      {ctrl, mode} = 22'h000000;
    else if (a == 5'h0D)
      ctrl = v;
    else if (a == 5'h0E)
      mode = v;
  endtask : wr
  task print_verdict();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // ==========
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      lf = lfsr_next(lf);
      apply(i < 4 ? {2'h2, {5{i[1:0]}}} : {1'b1, lf[10:0]});
      chk();
    end
    $display("pin-only sweep done");
    apply(12'h39C);
    wr(5'h00, 11'h002);
    chk();
    wr(5'h0D, 11'h00F);
    chk();
    wr(5'h0D, 11'h014);
    chk();
    apply(12'h79C);
    chk();
    apply(12'h39F);
    chk();
    $display("combined mode done");
    wr(5'h0E, 11'h4C0);
    chk();
    wr(5'h0D, 11'h40A);
    chk();
    wr(5'h05, 11'h7FF);
    chk();
    for (int i = 0; i < 6; i++)
    begin
      lf = lfsr_next(lf);
      d = lf[10:0];
      if (d[4:3] == 2'h3)
        d[4] = 1'b0;
      wr(i[0] ? 5'h0D : 5'h0E, d);
      chk();
    end
    wr(5'h00, 11'h002);
    chk();
    wr(5'h0D, 11'h400);
    apply(12'hB9C);
    chk();
    apply(12'h39C);
    chk();
    $display("serial-only mode done");
    print_verdict();
  end
endmodule : config_source_priority_control_tb
`default_nettype wire
